// ==== common/bmcu_pkg.sv ====
// shared constants for the master control/status upper half
package bmcu_pkg;
    // field positions within master_control_status
    localparam int NV_ENABLE_READY_BIT = 31;
    localparam int NV_OP_SELECT_HI     = 30;
    localparam int NV_OP_SELECT_LO     = 29;
    localparam int MBOX_RESET_BIT      = 27;
    localparam int OUT_FIFO_RESET_BIT  = 26;
    localparam int IN_FIFO_RESET_BIT   = 25;
    localparam int ADDON_RESET_BIT     = 24;
    localparam int NV_PORT_MSB         = 23;
    localparam int NV_PORT_LSB         = 16;
    localparam int RD_MRM_BIT          = 15;
    localparam int RD_ENABLE_BIT       = 14;
    localparam int RD_FIFO_MGMT_BIT    = 13;
    // register placement and reset
    localparam logic [7:0]  MCS_OFFSET    = 8'h3C;
    localparam logic [31:0] MCS_RESET_VAL = 32'h000000E6;
    // nv access codes on the op select pair
    localparam logic [1:0] NV_OP_LOAD_LO = 2'h0;
    localparam logic [1:0] NV_OP_LOAD_HI = 2'h1;
    localparam logic [1:0] NV_OP_WRITE   = 2'h2;
    localparam logic [1:0] NV_OP_READ    = 2'h3;
    // inbound vacancy threshold for managed requests
    localparam int RD_VACANCY_THRESH = 4;
    // nv engine states, gray along idle -> access -> release
    typedef enum logic [1:0]
    {
        BMCU_NV_IDLE    = 2'b00,
        BMCU_NV_ACCESS  = 2'b01,
        BMCU_NV_RELEASE = 2'b11
    } bmcu_nv_state_t;
endpackage : bmcu_pkg

// ==== common/bmcu_nv_if.sv ====
// carrier between the register bank and the nv access engine
`timescale 1ns/1ps
interface bmcu_nv_if;
    logic        start;    // one-cycle pulse, begin an access
    logic        is_read;  // access kind, valid with start
    logic [15:0] addr;     // byte address
    logic [7:0]  wdata;    // byte to write
    logic        busy;     // engine occupied
    logic        done;     // one-cycle pulse, access finished
    logic [7:0]  rdata;    // fetched byte, valid with done
    modport ctrl (output start, is_read, addr, wdata, input busy, done, rdata);
    modport eng  (input start, is_read, addr, wdata, output busy, done, rdata);
endinterface : bmcu_nv_if

// ==== core/bmcu_nv_engine.sv ====
// byte-serial engine toward the external nonvolatile memory
`timescale 1ns/1ps
module bmcu_nv_engine
    import bmcu_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    // register side
    bmcu_nv_if.eng           nv,
    // memory pins
    output logic      [15:0] nv_addr_o,
    output logic      [7:0]  nv_wdata_o,
    output logic             nv_wr_o,
    output logic             nv_rd_o,
    input  wire logic [7:0]  nv_rdata_i,
    input  wire logic        nv_ack_i
);
    bmcu_nv_state_t state_reg;
    logic [2:0]     ack_sync_reg;
    logic           ack_reg;
    logic [7:0]     rdata_reg;
    logic           done_reg;

    // three-stage sync; the level moves only when stages two and three agree
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack_sync_reg <= 3'h0;
            ack_reg      <= 1'b0;
        end
        else
        begin
            ack_sync_reg <= {ack_sync_reg[1:0], nv_ack_i};
            if (ack_sync_reg[1] == ack_sync_reg[2])
                ack_reg <= ack_sync_reg[2];
        end
    end

    // full four-phase handshake: strobe held until ack, then wait ack low
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg  <= BMCU_NV_IDLE;
            nv_addr_o  <= 16'h0000;
            nv_wdata_o <= 8'h00;
            nv_wr_o    <= 1'b0;
            nv_rd_o    <= 1'b0;
            rdata_reg  <= 8'h00;
            done_reg   <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            unique case (state_reg)
                BMCU_NV_IDLE:
                begin
                    if (nv.start)
                    begin
                        nv_addr_o  <= nv.addr;
                        nv_wdata_o <= nv.wdata;
                        nv_wr_o    <= ~nv.is_read;
                        nv_rd_o    <= nv.is_read;
                        state_reg  <= BMCU_NV_ACCESS;
                    end
                end
                BMCU_NV_ACCESS:
                begin
                    if (ack_reg)
                    begin
                        if (nv_rd_o)
                            rdata_reg <= nv_rdata_i;
                        nv_wr_o   <= 1'b0;
                        nv_rd_o   <= 1'b0;
                        state_reg <= BMCU_NV_RELEASE;
                    end
                end
                BMCU_NV_RELEASE:
                begin
                    if (!ack_reg)
                    begin
                        done_reg  <= 1'b1;
                        state_reg <= BMCU_NV_IDLE;
                    end
                end
                default:
                    state_reg <= BMCU_NV_IDLE;
            endcase
        end
    end

    // busy rises the cycle after start and covers the done cycle, so ready never shows before the port byte is loaded
    assign nv.busy  = (state_reg != BMCU_NV_IDLE) || done_reg;
    assign nv.done  = done_reg;
    assign nv.rdata = rdata_reg;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence read_started_s;
        nv.start && nv.is_read && !nv.busy;
    endsequence

    nv_read_strobe_a: assert property (read_started_s |=> nv_rd_o && !nv_wr_o)
        else $error("nv read strobe not raised after read start");
    nv_done_idle_a: assert property (done_reg |-> !nv_wr_o && !nv_rd_o && !ack_reg)
        else $error("nv access finished with strobe or ack still high");
endmodule : bmcu_nv_engine

// ==== core/bmcu_ctrl.sv ====
// master control/status upper half: nv port, reset pulses, read bus-master controls
// Behaviour
// - the 8-bit port field is taken as low address, high address or data per the two op select bits.
// - after a begin-read access the fetched nv byte appears in the port field.
// - the top bit starts an access when written one and reads one while busy; software waits for zero.
// - writing one to the mailbox reset bit empties every mailbox flag.
// - the three reset bits are write-only one-cycle pulses that read back zero.
// - the outbound reset sets empty and clears full and four-plus-words.
// - the inbound reset sets empty, clears full and sets four-plus-spaces.
// - the add-on reset bit drives the reset pin until zero is written and reads back.
// - with the read-multiple bit set, master reads use the memory read multiple command.
// - master read transfers run only while the read enable bit is one.
// - clearing read enable suspends a nonzero count without discarding it.
// - with read fifo management set, no read request until four inbound words are vacant.
// - the four-vacancy threshold is void once granted or owning the bus through the write channel.
// - with read fifo management clear, request whenever one inbound word is vacant.
`timescale 1ns/1ps
module bmcu_ctrl
    import bmcu_pkg::*;
#(
    parameter int VAC_W = 4
)
(
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    // register port
    input  wire logic             reg_wr_i,
    input  wire logic [31:0]      reg_wdata_i,
    output logic      [31:0]      reg_rdata_o,
    // fifo and mailbox flag control
    output logic                  mbox_flags_empty_o,
    output logic                  out_fifo_flag_reset_o,
    output logic                  out_fifo_empty_set_o,
    output logic                  out_fifo_full_clr_o,
    output logic                  out_fifo_four_clr_o,
    output logic                  in_fifo_flag_reset_o,
    output logic                  in_fifo_empty_set_o,
    output logic                  in_fifo_full_clr_o,
    output logic                  in_fifo_four_set_o,
    // add-on reset pin
    output logic                  addon_reset_o,
    // read bus-master channel
    input  wire logic             rd_count_zero_i,
    input  wire logic [VAC_W-1:0] in_fifo_vacant_i,
    input  wire logic             bus_granted_i,
    input  wire logic             bus_owned_write_i,
    output logic                  rd_xfer_run_o,
    output logic                  rd_bus_req_o,
    output logic                  rd_cmd_mrm_o,
    // nonvolatile memory pins
    output logic      [15:0]      nv_addr_o,
    output logic      [7:0]       nv_wdata_o,
    output logic                  nv_wr_o,
    output logic                  nv_rd_o,
    input  wire logic [7:0]       nv_rdata_i,
    input  wire logic             nv_ack_i
);
    bmcu_nv_if nv ();

    logic [7:0] nv_addr_lo_reg;
    logic [7:0] nv_addr_hi_reg;
    logic [7:0] nv_port_reg;
    logic       mbox_pulse_reg;
    logic       out_pulse_reg;
    logic       in_pulse_reg;
    logic       addon_rst_reg;
    logic       rd_mrm_reg;
    logic       rd_en_reg;
    logic       rd_mgmt_reg;
    logic       rd_access_reg;
    logic       nv_cmd;
    logic [1:0] nv_op;
    logic       vac_one;
    logic       vac_four;

    // decode of one field bit on a register write
    function automatic logic wr_bit(input logic wr, input logic [31:0] d, input int pos);
        wr_bit = wr && d[pos];
    endfunction : wr_bit

    // nv command only counts while the engine is ready; a write during busy is dropped
    assign nv_cmd = wr_bit(reg_wr_i, reg_wdata_i, NV_ENABLE_READY_BIT) && !nv.busy;
    assign nv_op  = {reg_wdata_i[NV_OP_SELECT_HI], reg_wdata_i[NV_OP_SELECT_LO]};

    // address bytes and port byte; a finished read overwrites the port byte
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            nv_addr_lo_reg <= 8'h00;
            nv_addr_hi_reg <= 8'h00;
            nv_port_reg    <= 8'h00;
        end
        else if (nv.done && rd_access_reg)
        begin
            nv_port_reg <= nv.rdata;
        end
        else if (nv_cmd)
        begin
            unique case (nv_op)
                NV_OP_LOAD_LO: nv_addr_lo_reg <= reg_wdata_i[NV_PORT_MSB:NV_PORT_LSB];
                NV_OP_LOAD_HI: nv_addr_hi_reg <= reg_wdata_i[NV_PORT_MSB:NV_PORT_LSB];
                NV_OP_WRITE:   nv_port_reg    <= reg_wdata_i[NV_PORT_MSB:NV_PORT_LSB];
                NV_OP_READ:    nv_port_reg    <= nv_port_reg;
            endcase
        end
    end

    // access kind latched at start so the finish knows whether to load the port
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rd_access_reg <= 1'b0;
        else if (nv.start)
            rd_access_reg <= nv.is_read;
    end

    // begin codes 110 and 111 hand the access to the engine
    assign nv.start   = nv_cmd && nv_op[1];
    assign nv.is_read = (nv_op == NV_OP_READ);
    assign nv.addr    = {nv_addr_hi_reg, nv_addr_lo_reg};
    assign nv.wdata   = (nv_op == NV_OP_WRITE) ? reg_wdata_i[NV_PORT_MSB:NV_PORT_LSB] : nv_port_reg;

    bmcu_nv_engine u_nv_engine
    (
        .sys_clk_i  (sys_clk_i),
        .reset_n_i  (reset_n_i),
        .nv         (nv),
        .nv_addr_o  (nv_addr_o),
        .nv_wdata_o (nv_wdata_o),
        .nv_wr_o    (nv_wr_o),
        .nv_rd_o    (nv_rd_o),
        .nv_rdata_i (nv_rdata_i),
        .nv_ack_i   (nv_ack_i)
    );

    // self-clearing reset pulses, one cycle after the write
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mbox_pulse_reg <= 1'b0;
            out_pulse_reg  <= 1'b0;
            in_pulse_reg   <= 1'b0;
        end
        else
        begin
            mbox_pulse_reg <= wr_bit(reg_wr_i, reg_wdata_i, MBOX_RESET_BIT);
            out_pulse_reg  <= wr_bit(reg_wr_i, reg_wdata_i, OUT_FIFO_RESET_BIT);
            in_pulse_reg   <= wr_bit(reg_wr_i, reg_wdata_i, IN_FIFO_RESET_BIT);
        end
    end

    // flag presets carried by each pulse
    assign mbox_flags_empty_o    = mbox_pulse_reg;
    assign out_fifo_flag_reset_o = out_pulse_reg;
    assign out_fifo_empty_set_o  = out_pulse_reg;
    assign out_fifo_full_clr_o   = out_pulse_reg;
    assign out_fifo_four_clr_o   = out_pulse_reg;
    assign in_fifo_flag_reset_o  = in_pulse_reg;
    assign in_fifo_empty_set_o   = in_pulse_reg;
    assign in_fifo_full_clr_o    = in_pulse_reg;
    assign in_fifo_four_set_o    = in_pulse_reg;

    // plain read/write control bits
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            addon_rst_reg <= MCS_RESET_VAL[ADDON_RESET_BIT];
            rd_mrm_reg    <= MCS_RESET_VAL[RD_MRM_BIT];
            rd_en_reg     <= MCS_RESET_VAL[RD_ENABLE_BIT];
            rd_mgmt_reg   <= MCS_RESET_VAL[RD_FIFO_MGMT_BIT];
        end
        else if (reg_wr_i)
        begin
            addon_rst_reg <= reg_wdata_i[ADDON_RESET_BIT];
            rd_mrm_reg    <= reg_wdata_i[RD_MRM_BIT];
            rd_en_reg     <= reg_wdata_i[RD_ENABLE_BIT];
            rd_mgmt_reg   <= reg_wdata_i[RD_FIFO_MGMT_BIT];
        end
    end

    assign addon_reset_o = addon_rst_reg;
    assign rd_cmd_mrm_o  = rd_mrm_reg;

    // the count lives outside; gating here only pauses it, so nothing is lost
    assign rd_xfer_run_o = rd_en_reg && !rd_count_zero_i;
    assign vac_one       = (in_fifo_vacant_i != '0);
    assign vac_four      = (in_fifo_vacant_i >= VAC_W'(RD_VACANCY_THRESH));
    // threshold waived while the bus is already ours; a grant still never requests into a full fifo
    assign rd_bus_req_o  = rd_xfer_run_o && vac_one &&
                           (!rd_mgmt_reg || vac_four || bus_granted_i || bus_owned_write_i);

    // readback; pulse bits and excluded lower bits read zero
    always_comb
    begin
        reg_rdata_o                             = 32'h00000000;
        reg_rdata_o[NV_ENABLE_READY_BIT]        = nv.busy;
        reg_rdata_o[ADDON_RESET_BIT]            = addon_rst_reg;
        reg_rdata_o[NV_PORT_MSB:NV_PORT_LSB]    = nv_port_reg;
        reg_rdata_o[RD_MRM_BIT]                 = rd_mrm_reg;
        reg_rdata_o[RD_ENABLE_BIT]              = rd_en_reg;
        reg_rdata_o[RD_FIFO_MGMT_BIT]           = rd_mgmt_reg;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence mbox_write_s;
        reg_wr_i && reg_wdata_i[MBOX_RESET_BIT];
    endsequence

    nv_port_load_a: assert property (nv_cmd && nv_op == NV_OP_LOAD_LO |=>
        nv_addr_lo_reg == $past(reg_wdata_i[NV_PORT_MSB:NV_PORT_LSB]))
        else $error("low address byte not captured");
    nv_busy_read_a: assert property (nv.start |=> reg_rdata_o[NV_ENABLE_READY_BIT] [*2])
        else $error("busy not shown after begin code");
    mbox_reset_pulse_a: assert property (mbox_write_s |=> mbox_flags_empty_o ##1 !mbox_flags_empty_o || $past(reg_wr_i && reg_wdata_i[MBOX_RESET_BIT]))
        else $error("mailbox reset pulse wrong");
    pulse_readback_a: assert property (reg_rdata_o[MBOX_RESET_BIT:IN_FIFO_RESET_BIT] == 3'h0)
        else $error("reset pulse bit reads nonzero");
    out_fifo_reset_a: assert property (reg_wr_i && reg_wdata_i[OUT_FIFO_RESET_BIT] |=>
        out_fifo_empty_set_o && out_fifo_full_clr_o && out_fifo_four_clr_o)
        else $error("outbound flag reset missing");
    in_fifo_reset_a: assert property (reg_wr_i && reg_wdata_i[IN_FIFO_RESET_BIT] |=>
        in_fifo_empty_set_o && in_fifo_full_clr_o && in_fifo_four_set_o)
        else $error("inbound flag reset missing");
    addon_pin_a: assert property (reg_wr_i |=> addon_reset_o == $past(reg_wdata_i[ADDON_RESET_BIT]))
        else $error("add-on reset pin does not follow write");
    rd_gate_a: assert property (!rd_en_reg || rd_count_zero_i |-> !rd_bus_req_o && !rd_xfer_run_o)
        else $error("read request without enable or count");
    rd_thresh_a: assert property (rd_bus_req_o && rd_mgmt_reg && !bus_granted_i && !bus_owned_write_i
        |-> in_fifo_vacant_i >= VAC_W'(RD_VACANCY_THRESH))
        else $error("managed read request below four vacancies");
    rd_one_vacant_a: assert property (rd_xfer_run_o && !rd_mgmt_reg && in_fifo_vacant_i != '0 |-> rd_bus_req_o)
        else $error("unmanaged read request missing");
endmodule : bmcu_ctrl

// ==== tb/tb_bus_master_control_upper.sv ====
// self-checking bench for the master control/status upper half
`timescale 1ns/1ps
module tb_bus_master_control_upper
    import bmcu_pkg::*;
;
    typedef struct { int sel; logic [31:0] exp; } bmcu_note_t;
    // clock, reset and register port
    logic        sys_clk_i;
    logic        reset_n_i;
    logic        reg_wr_i;
    logic [31:0] reg_wdata_i;
    logic [31:0] reg_rdata_o;
    // presets, add-on reset and read master
    logic [8:0]  pulse_vec;
    logic        addon_reset_o;
    logic        rd_count_zero_i;
    logic [3:0]  in_fifo_vacant_i;
    logic        bus_granted_i;
    logic        bus_owned_write_i;
    logic        rd_xfer_run_o;
    logic        rd_bus_req_o;
    logic        rd_cmd_mrm_o;
    // nonvolatile memory pins
    logic [15:0] nv_addr_o;
    logic [7:0]  nv_wdata_o;
    logic        nv_wr_o;
    logic        nv_rd_o;
    logic [7:0]  nv_rdata_i;
    logic        nv_ack_i;
    // bench state
    bmcu_note_t  notes[$];
    bmcu_note_t  cur;
    logic [31:0] got;
    logic [15:0] rnd;
    logic [3:0]  ctl;        // addon, mrm, rd enable, fifo mgmt
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  wd;         // byte of the nv write, still in the port for the read
    logic        run_e;
    logic        req_e;
    int          bad_count;
    int          total_checks;
    string       sel_name [7] = '{"readback", "presets", "control outs", "nv strobe addr", "busy bit",
                                  "port byte", "nv wdata"};
    logic [31:0] rst_bits [4] = '{32'h08000000, 32'h04000000, 32'h02000000, 32'h0E000000};
    logic [8:0]  rst_vec  [4] = '{9'h100, 9'h0F0, 9'h00F, 9'h1FF};

    bmcu_ctrl #(.VAC_W(4)) i_dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .mbox_flags_empty_o(pulse_vec[8]), .out_fifo_flag_reset_o(pulse_vec[7]),
        .out_fifo_empty_set_o(pulse_vec[6]), .out_fifo_full_clr_o(pulse_vec[5]),
        .out_fifo_four_clr_o(pulse_vec[4]), .in_fifo_flag_reset_o(pulse_vec[3]),
        .in_fifo_empty_set_o(pulse_vec[2]), .in_fifo_full_clr_o(pulse_vec[1]), .in_fifo_four_set_o(pulse_vec[0]),
        .addon_reset_o(addon_reset_o), .rd_count_zero_i(rd_count_zero_i), .in_fifo_vacant_i(in_fifo_vacant_i),
        .bus_granted_i(bus_granted_i), .bus_owned_write_i(bus_owned_write_i), .rd_xfer_run_o(rd_xfer_run_o),
        .rd_bus_req_o(rd_bus_req_o), .rd_cmd_mrm_o(rd_cmd_mrm_o), .nv_addr_o(nv_addr_o),
        .nv_wdata_o(nv_wdata_o), .nv_wr_o(nv_wr_o), .nv_rd_o(nv_rd_o), .nv_rdata_i(nv_rdata_i),
        .nv_ack_i(nv_ack_i));

    // free-running bench clock, 40 ns
    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // register word with the stored control bits carried along
    function automatic logic [31:0] mk(input logic [2:0] nv3, input logic [7:0] b);
        return {nv3, 4'h0, ctl[3], b, ctl[2:0], 13'h0};
    endfunction : mk

    function automatic logic [31:0] observe(input int sel);
        case (sel)
            0: return reg_rdata_o;
            1: return {23'h0, pulse_vec};
            2: return {28'h0, addon_reset_o, rd_xfer_run_o, rd_bus_req_o, rd_cmd_mrm_o};
            3: return {14'h0, nv_wr_o, nv_rd_o, nv_addr_o};
            4: return {31'h0, reg_rdata_o[31]};
            5: return {24'h0, reg_rdata_o[23:16]};
            default: return {24'h0, nv_wdata_o};
        endcase
    endfunction : observe

    task automatic note(input int sel, input logic [31:0] exp);
        bmcu_note_t n;
        n.sel = sel;
        n.exp = exp;
        notes.push_back(n);
    endtask : note

    // one-cycle write strobe; request changes only just after an edge
    task automatic wr(input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    // bench plays the memory: four-phase ack, data released afterwards
    task automatic serve(input logic is_wr, input logic [15:0] a, input logic [7:0] d, input logic [7:0] rb);
        int n;
        n = 0;
        while (!(nv_wr_o === 1'b1 || nv_rd_o === 1'b1) && n < 10)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
        note(3, {14'h0, is_wr, ~is_wr, a});
        note(4, 32'h1);
        note(6, {24'h0, d});
        wr(mk(3'b110, ~d));
        note(3, {14'h0, is_wr, ~is_wr, a});
        rnd = lfsr(rnd);
        repeat (rnd[1:0]) @(posedge sys_clk_i);
        nv_ack_i   <= 1'b1;
        nv_rdata_i <= rb;
        while ((nv_wr_o === 1'b1 || nv_rd_o === 1'b1) && n < 30)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
        nv_ack_i   <= 1'b0;
        nv_rdata_i <= ~rb;
        while (reg_rdata_o[31] !== 1'b0 && n < 50)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
        note(4, 32'h0);
        note(5, {24'h0, is_wr ? d : rb});
    endtask : serve

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // watcher: outputs are settled at the falling edge, oldest note first
    always @(negedge sys_clk_i)
    begin
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            got = observe(cur.sel);
            total_checks++;
            if (got !== cur.exp)
            begin
                bad_count++;
                $display("BAD %s expected %h seen %h", sel_name[cur.sel], cur.exp, got);
            end
        end
    end

    // watchdog sized well above the expected few hundred cycles
    initial
    begin
        #200000;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        reset_n_i = 1'b0; reg_wr_i = 1'b0; reg_wdata_i = 32'h0; rd_count_zero_i = 1'b1;
        in_fifo_vacant_i = 4'h0; bus_granted_i = 1'b0; bus_owned_write_i = 1'b0;
        nv_rdata_i = 8'h00; nv_ack_i = 1'b0; ctl = 4'h0; rnd = 16'h3F56;
        bad_count = 0; total_checks = 0;
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        note(0, 32'h0);
        note(1, 32'h0);
        note(2, 32'h0);
        // reset pulses, alternating the add-on reset level
        for (int i = 0; i < 4; i++)
        begin
            ctl[3] = i[0];
            wr(mk(3'b000, 8'h00) | rst_bits[i]);
            note(1, {23'h0, rst_vec[i]});
            note(0, {7'h0, ctl[3], 24'h0});
            note(2, {28'h0, ctl[3], 3'b000});
            @(posedge sys_clk_i);
            note(1, 32'h0);
        end
        // read master controls with random flags; nv part left inactive
        for (int i = 0; i < 48; i++)
        begin
            rnd = lfsr(rnd);
            ctl = rnd[3:0];
            wr(mk({1'b0, rnd[5:4]}, rnd[15:8]));
            rnd = lfsr(rnd);
            rd_count_zero_i   <= rnd[0];
            in_fifo_vacant_i  <= rnd[7:4];
            bus_granted_i     <= rnd[1];
            bus_owned_write_i <= rnd[2];
            run_e = ctl[1] & ~rnd[0];
            req_e = run_e & (rnd[7:4] != 4'h0) & (~ctl[0] | rnd[7:4] >= RD_VACANCY_THRESH | rnd[1] | rnd[2]);
            note(2, {28'h0, ctl[3], run_e, req_e, ctl[2]});
            note(0, {7'h0, ctl[3], 8'h00, ctl[2:0], 13'h0});
            note(3, 32'h0);
        end
        // nv write: low, high, then begin write with data; only this side touches the nv port
        rnd = lfsr(rnd);
        lo = rnd[7:0];
        hi = rnd[15:8];
        rnd = lfsr(rnd);
        wd = rnd[7:0];
        wr(mk(3'b100, lo));
        wr(mk(3'b101, hi));
        wr(mk(3'b110, rnd[7:0]));
        serve(1'b1, {hi, lo}, rnd[7:0], 8'h00);
        // nv read of a fresh address
        rnd = lfsr(rnd);
        lo = rnd[7:0];
        hi = rnd[15:8];
        wr(mk(3'b100, lo));
        wr(mk(3'b101, hi));
        wr(mk(3'b111, 8'h00));
        rnd = lfsr(rnd);
        serve(1'b0, {hi, lo}, wd, rnd[15:8]);
        @(negedge sys_clk_i);
        #1;
        report_and_stop();
    end
endmodule : tb_bus_master_control_upper
